// [verilog/wote_engine.v]
// Purpose: timing engine for hardware-timed waveform output
// Assumes: all sources synchronous to core_clk; slow base is an enable-style input
// Notes:   register port: addr/wdata with one-cycle strobes, read data next cycle
`timescale 1ns/1ps
`include "wote_consts.vh"

module wote_engine
(
    input  wire                        core_clk,
    input  wire                        rst,
    input  wire [`WOTE_ADDR_W-1:0]     reg_addr,
    input  wire [31:0]                 reg_wdata,
    input  wire                        reg_wr,
    input  wire                        reg_rd,
    output reg  [31:0]                 reg_rdata,
    input  wire                        fast_base_clock,
    input  wire                        slow_base_clock,
    input  wire [`WOTE_NTERM-1:0]      pft_in,
    input  wire [`WOTE_NLINE-1:0]      ctl_in,
    input  wire [`WOTE_NSRC-1:0]       internal_src,
    input  wire                        analog_cmp_event,
    output reg  [`WOTE_NTERM-1:0]      pft_out,
    output reg  [`WOTE_NTERM-1:0]      pft_oe,
    output reg  [`WOTE_NLINE-1:0]      ctl_out,
    output reg  [`WOTE_NLINE-1:0]      ctl_oe,
    output reg  [`WOTE_NCONV-1:0]      conv_update,
    output reg                         wave_running
);

// ****************************************
// source selection
// ****************************************
// sources 0..15 terminals, 16..22 trigger lines 0..6, 24..31 internal
function sel_src;
    input [4:0]  sel;
    input [15:0] terms;
    input [7:0]  lines;
    input [7:0]  ints;
    reg   [31:0] all;
    begin
        all = {ints, 1'b0, lines[6:0], terms};
        sel_src = all[sel];
    end
endfunction

reg  [`WOTE_CTRL_W-1:0] ctrl_reg;
reg  [31:0]             divide_reg;
reg  [31:0]             delay_reg;
reg  [31:0]             count_reg;
reg  [31:0]             route_reg;
reg  [31:0]             done_cnt_reg;
reg  [31:0]             div_cnt_reg;
reg  [31:0]             dly_cnt_reg;
reg  [1:0]              state_reg;
reg                     tb_prev_reg;
reg                     trig_prev_reg;
reg                     upd_prev_reg;
reg                     upd_clk_reg;
reg                     begin_pulse_reg;
reg                     sw_start_reg;
reg                     sw_stop_reg;

wire [1:0] tb_sel    = ctrl_reg[`WOTE_TB_SEL_HI:`WOTE_TB_SEL_LO];
wire [1:0] trig_mode = ctrl_reg[`WOTE_TRIG_HI:`WOTE_TRIG_LO];
wire [1:0] hold_mode = ctrl_reg[`WOTE_HOLD_HI:`WOTE_HOLD_LO];
wire [4:0] tb_src_sel   = route_reg[`WOTE_RT_TB_HI:`WOTE_RT_TB_LO];
wire [4:0] trig_src_sel = route_reg[`WOTE_RT_TRIG_HI:`WOTE_RT_TRIG_LO];
wire [4:0] hold_src_sel = route_reg[`WOTE_RT_HOLD_HI:`WOTE_RT_HOLD_LO];
wire [4:0] upd_src_sel  = route_reg[`WOTE_RT_UPD_HI:`WOTE_RT_UPD_LO];
wire [2:0] upd_tgt      = route_reg[`WOTE_RT_TGT_HI:`WOTE_RT_TGT_LO];
wire [3:0] trig_tgt     = route_reg[`WOTE_RT_TOUT_HI:`WOTE_RT_TOUT_LO];
wire       upd_out_en   = route_reg[`WOTE_RT_UOUT_BIT];
wire       trig_out_en  = route_reg[`WOTE_RT_TOUT_BIT];
wire       upd_to_line  = route_reg[`WOTE_RT_LINE_BIT];

// ****************************************
// timebase
// ****************************************
// terminal or internal timebase, input only
// otherwise fast or slow base clock
reg tb_raw;
always @*
begin
    case (tb_sel)
        `WOTE_TB_FAST: tb_raw = fast_base_clock;
        `WOTE_TB_SLOW: tb_raw = slow_base_clock;
        default:       tb_raw = sel_src(tb_src_sel, pft_in, ctl_in, internal_src);
    endcase
end

wire tb_edge = ctrl_reg[`WOTE_TB_FALL_BIT] ? (tb_prev_reg & ~tb_raw)
                                           : (~tb_prev_reg & tb_raw);

// ****************************************
// start trigger
// ****************************************
wire trig_raw = (trig_mode == `WOTE_TRIG_ANA) ? analog_cmp_event
              : sel_src(trig_src_sel, pft_in, ctl_in, internal_src);
wire trig_edge = (trig_mode == `WOTE_TRIG_DIG && ctrl_reg[`WOTE_TRIG_FALL_BIT])
               ? (trig_prev_reg & ~trig_raw) : (~trig_prev_reg & trig_raw);
wire start_evt = (trig_mode == `WOTE_TRIG_SW) ? sw_start_reg : trig_edge;

// ****************************************
// hold gate
// ****************************************
// digital source and level
wire hold_dig = sel_src(hold_src_sel, pft_in, ctl_in, internal_src);
wire hold_on  = (hold_mode == `WOTE_HOLD_DIG) ? (hold_dig ^ ctrl_reg[`WOTE_HOLD_LOW_BIT])
              : (hold_mode == `WOTE_HOLD_ANA) ? analog_cmp_event : 1'b0;

// ****************************************
// update clock
// ****************************************
wire upd_raw  = sel_src(upd_src_sel, pft_in, ctl_in, internal_src);
// converter edge select on external update clock
wire upd_edge = ctrl_reg[`WOTE_UPD_FALL_BIT] ? (upd_prev_reg & ~upd_raw)
                                             : (~upd_prev_reg & upd_raw);
wire ext_upd  = ctrl_reg[`WOTE_EXT_UPD_BIT];
wire div_tick = tb_edge && (div_cnt_reg <= `WOTE_ONE32);
wire upd_evt  = (state_reg == `WOTE_ST_RUN) && (ext_upd ? upd_edge : div_tick);
// hold masks pulses; sampled at pulse start so a pulse under way completes
// every update is masked for as long as hold is on
wire upd_fire = upd_evt && !hold_on;
wire finite   = ctrl_reg[`WOTE_FINITE_BIT];
wire last_smp = finite && upd_fire && (done_cnt_reg + `WOTE_ONE32 >= count_reg);

// ****************************************
// edge history
// ****************************************
// history resets to the idle low level so no false edge follows reset
always @(posedge core_clk)
begin
    if (rst)
    begin
        tb_prev_reg   <= 1'b0;
        trig_prev_reg <= 1'b0;
        upd_prev_reg  <= 1'b0;
    end
    else
    begin
        tb_prev_reg   <= tb_raw;
        trig_prev_reg <= trig_raw;
        upd_prev_reg  <= upd_raw;
    end
end

// ****************************************
// register port
// ****************************************
always @(posedge core_clk)
begin
    if (rst)
    begin
        ctrl_reg     <= {`WOTE_CTRL_W{1'b0}};
        divide_reg   <= `WOTE_DIVIDE_RST;
        delay_reg    <= `WOTE_DELAY_RST;
        count_reg    <= `WOTE_ZERO32;
        route_reg    <= `WOTE_ZERO32;
        sw_start_reg <= 1'b0;
        sw_stop_reg  <= 1'b0;
        reg_rdata    <= `WOTE_ZERO32;
    end
    else
    begin
        sw_start_reg <= reg_wr && reg_addr == `WOTE_OFF_CMD && reg_wdata[`WOTE_CMD_START_BIT];
        sw_stop_reg  <= reg_wr && reg_addr == `WOTE_OFF_CMD && reg_wdata[`WOTE_CMD_STOP_BIT];
        if (reg_wr)
        begin
            case (reg_addr)
                `WOTE_OFF_CTRL:   ctrl_reg   <= reg_wdata[`WOTE_CTRL_W-1:0];
                `WOTE_OFF_DIVIDE: divide_reg <= reg_wdata;
                `WOTE_OFF_DELAY:  delay_reg  <= reg_wdata;
                `WOTE_OFF_COUNT:  count_reg  <= reg_wdata;
                `WOTE_OFF_ROUTE:  route_reg  <= reg_wdata;
                default:          ;
            endcase
        end
        // unmapped reads return zero
        if (reg_rd)
        begin
            case (reg_addr)
                `WOTE_OFF_CTRL:     reg_rdata <= {20'h00000, ctrl_reg};
                `WOTE_OFF_DIVIDE:   reg_rdata <= divide_reg;
                `WOTE_OFF_DELAY:    reg_rdata <= delay_reg;
                `WOTE_OFF_COUNT:    reg_rdata <= count_reg;
                `WOTE_OFF_STATUS:   reg_rdata <= {30'h00000000, state_reg};
                `WOTE_OFF_ROUTE:    reg_rdata <= route_reg;
                `WOTE_OFF_DONE_CNT: reg_rdata <= done_cnt_reg;
                default:            reg_rdata <= `WOTE_ZERO32;
            endcase
        end
        else
        begin
            // zero outside the read cycle so a stale word never looks valid
            reg_rdata <= `WOTE_ZERO32;
        end
    end
end

// ****************************************
// sequencer
// ****************************************
always @(posedge core_clk)
begin
    if (rst)
    begin
        done_cnt_reg    <= `WOTE_ZERO32;
        div_cnt_reg     <= `WOTE_ZERO32;
        dly_cnt_reg     <= `WOTE_ZERO32;
        state_reg       <= `WOTE_ST_IDLE;
        upd_clk_reg     <= 1'b0;
        begin_pulse_reg <= 1'b0;
        conv_update     <= {`WOTE_NCONV{1'b0}};
        wave_running    <= 1'b0;
    end
    else
    begin
        begin_pulse_reg <= 1'b0;
        case (state_reg)
            `WOTE_ST_IDLE:
            begin
                if (start_evt && !sw_stop_reg)
                begin
                    begin_pulse_reg <= 1'b1;
                    done_cnt_reg    <= `WOTE_ZERO32;
                    dly_cnt_reg     <= delay_reg;
                    div_cnt_reg     <= divide_reg;
                    state_reg       <= ext_upd ? `WOTE_ST_RUN : `WOTE_ST_DELAY;
                end
            end
            `WOTE_ST_DELAY:
            begin
                // count delay in timebase ticks
                // the last delay tick is the divider's first terminal edge,
                // so delays below two still take two ticks
                if (sw_stop_reg)
                    state_reg <= `WOTE_ST_IDLE;
                else if (tb_edge)
                begin
                    if (dly_cnt_reg <= `WOTE_TWO32)
                    begin
                        state_reg   <= `WOTE_ST_RUN;
                        div_cnt_reg <= `WOTE_ONE32;
                    end
                    else
                        dly_cnt_reg <= dly_cnt_reg - `WOTE_ONE32;
                end
            end
            `WOTE_ST_RUN:
            begin
                if (tb_edge)
                    div_cnt_reg <= div_tick ? divide_reg : div_cnt_reg - `WOTE_ONE32;
                if (upd_fire)
                    done_cnt_reg <= done_cnt_reg + `WOTE_ONE32;
                // halt on finite completion or software stop
                if (sw_stop_reg || last_smp)
                    state_reg <= `WOTE_ST_IDLE;
            end
            default:
                state_reg <= `WOTE_ST_IDLE;
        endcase

        // internal update clock, high for one cycle per update
        upd_clk_reg  <= upd_fire;
        conv_update  <= {`WOTE_NCONV{upd_fire}};
        wave_running <= state_reg != `WOTE_ST_IDLE;
    end
end

// ****************************************
// terminal drive
// ****************************************
// pins lag the internal pulses by one cycle; acceptable since pins only mirror them
always @(posedge core_clk)
begin
    if (rst)
    begin
        pft_out <= {`WOTE_NTERM{1'b0}};
        pft_oe  <= {`WOTE_NTERM{1'b0}};
        ctl_out <= {`WOTE_NLINE{1'b0}};
        ctl_oe  <= {`WOTE_NLINE{1'b0}};
    end
    else
    begin
        // hold gate has no output path; timebase has none either
        pft_oe  <= {`WOTE_NTERM{1'b0}};
        ctl_oe  <= {`WOTE_NLINE{1'b0}};
        pft_out <= {`WOTE_NTERM{1'b0}};
        ctl_out <= {`WOTE_NLINE{1'b0}};
        if (upd_out_en && upd_to_line)
        begin
            ctl_oe[upd_tgt]  <= 1'b1;
            ctl_out[upd_tgt] <= ~upd_clk_reg;
        end
        else if (upd_out_en)
        begin
            pft_oe[upd_tgt]  <= 1'b1;
            pft_out[upd_tgt] <= ~upd_clk_reg;
        end
        if (trig_out_en)
        begin
            pft_oe[trig_tgt]  <= 1'b1;
            pft_out[trig_tgt] <= begin_pulse_reg;
        end
    end
end

endmodule

// [verilog/wote_consts.vh]
// Purpose: constants for the waveform output timing engine
// Assumes: 20 MHz core clock
// Notes:   timing sources sampled as synchronous inputs
`ifndef WOTE_CONSTS_VH
`define WOTE_CONSTS_VH

// ****************************************
// register map (word offsets)
// ****************************************
`define WOTE_ADDR_W          4
`define WOTE_OFF_CTRL        4'h0
`define WOTE_OFF_CMD         4'h1
`define WOTE_OFF_DIVIDE      4'h2
`define WOTE_OFF_DELAY       4'h3
`define WOTE_OFF_COUNT       4'h4
`define WOTE_OFF_STATUS      4'h5
`define WOTE_OFF_ROUTE       4'h6
`define WOTE_OFF_DONE_CNT    4'h7

// ****************************************
// control fields
// ****************************************
`define WOTE_TB_SEL_LO       0
`define WOTE_TB_SEL_HI       1
`define WOTE_TB_FAST         2'h0
`define WOTE_TB_SLOW         2'h1
`define WOTE_TB_TERM         2'h2
`define WOTE_TB_INT          2'h3
`define WOTE_TB_FALL_BIT     2
`define WOTE_EXT_UPD_BIT     3
`define WOTE_UPD_FALL_BIT    4
`define WOTE_TRIG_LO         5
`define WOTE_TRIG_HI         6
`define WOTE_TRIG_SW         2'h0
`define WOTE_TRIG_DIG        2'h1
`define WOTE_TRIG_ANA        2'h2
`define WOTE_TRIG_FALL_BIT   7
`define WOTE_HOLD_LO         8
`define WOTE_HOLD_HI         9
`define WOTE_HOLD_NONE       2'h0
`define WOTE_HOLD_DIG        2'h1
`define WOTE_HOLD_ANA        2'h2
`define WOTE_HOLD_LOW_BIT    10
`define WOTE_FINITE_BIT      11
`define WOTE_CMD_START_BIT   0
`define WOTE_CMD_STOP_BIT    1
`define WOTE_CTRL_W          12

// ****************************************
// route fields
// ****************************************
`define WOTE_RT_TB_LO        0
`define WOTE_RT_TB_HI        4
`define WOTE_RT_TGT_LO       5
`define WOTE_RT_TGT_HI       7
`define WOTE_RT_TRIG_LO      8
`define WOTE_RT_TRIG_HI      12
`define WOTE_RT_HOLD_LO      16
`define WOTE_RT_HOLD_HI      20
`define WOTE_RT_TOUT_LO      20
`define WOTE_RT_TOUT_HI      23
`define WOTE_RT_UPD_LO       24
`define WOTE_RT_UPD_HI       28
`define WOTE_RT_LINE_BIT     29
`define WOTE_RT_TOUT_BIT     30
`define WOTE_RT_UOUT_BIT     31

// ****************************************
// sizes and reset values
// ****************************************
`define WOTE_CNT_W           32
`define WOTE_SEL_W           4
`define WOTE_NTERM           16
`define WOTE_NLINE           8
`define WOTE_NSRC            8
`define WOTE_NCONV           2
`define WOTE_DELAY_RST       32'h0000_0002
`define WOTE_DIVIDE_RST      32'h0000_0001
`define WOTE_ZERO32          32'h0000_0000
`define WOTE_ONE32           32'h0000_0001
`define WOTE_TWO32           32'h0000_0002
`define WOTE_ST_IDLE         2'h0
`define WOTE_ST_DELAY        2'h1
`define WOTE_ST_RUN          2'h2
`define WOTE_FAST_HZ         20000000
`define WOTE_SLOW_HZ         100000
`define WOTE_CORE_HZ         20000000

`endif

// [verification/wote_far_side.sv]
// Purpose: sources that stand on the engine's terminals
// Assumes: levels sampled at core_clk
// Notes:   timebase on terminal 0 (period 6), external update on 3 (period 10)
`timescale 1ns/1ps
module wote_far_side
(
    input  wire        core_clk,
    input  wire        rst,
    input  wire        trig,
    input  wire        hold,
    input  wire        ext_en,
    output wire [15:0] pft_in,
    output reg         fast_base_clock,
    output reg         slow_base_clock
);
    // ****************************************
    // free-running sources
    // ****************************************
    reg [7:0] slow_reg;
    reg [3:0] tick_reg;
    reg       tb_reg;
    reg       ext_reg;
    // idle terminals sit at their pull-down level
    assign pft_in = {12'h000, ext_reg, hold, trig, tb_reg};
    always @(posedge core_clk)
    begin
        // phases of 3 and 5 cycles
        tick_reg        <= (rst || tick_reg == 4'he) ? 4'h0 : tick_reg + 4'h1;
        tb_reg          <= !rst && (tb_reg ^ (tick_reg % 4'h3 == 4'h2));
        ext_reg         <= ext_en && (ext_reg ^ (tick_reg % 4'h5 == 4'h4));
        fast_base_clock <= !rst && !fast_base_clock;
        slow_reg        <= (rst || slow_reg == 8'hc7) ? 8'h00 : slow_reg + 8'h01;
        slow_base_clock <= slow_reg == 8'hc7;
    end
endmodule

// [verification/wote_engine_assertions.sv]
// Purpose: port assertions for the timing engine
// Assumes: one clock, synchronous reset
// Notes:   keeps its own shadow of route and control writes
`timescale 1ns/1ps
`include "wote_consts.vh"
module wote_engine_chk
(
    input wire                    core_clk,
    input wire                    rst,
    input wire [`WOTE_ADDR_W-1:0] reg_addr,
    input wire [31:0]             reg_wdata,
    input wire                    reg_wr,
    input wire                    analog_cmp_event,
    input wire [`WOTE_NTERM-1:0]  pft_out,
    input wire [`WOTE_NTERM-1:0]  pft_oe,
    input wire [`WOTE_NLINE-1:0]  ctl_oe,
    input wire [`WOTE_NCONV-1:0]  conv_update,
    input wire                    wave_running
);
    // ****************************************
    // shadow registers
    // ****************************************
    reg  [31:0] route_reg;
    reg  [11:0] ctrl_reg;
    wire        cmd_wr  = reg_wr && reg_addr == `WOTE_OFF_CMD;
    wire        upd_out = route_reg[31] && !route_reg[29];
    wire [15:0] upd_bit = 16'h0001 << route_reg[7:5];
    wire [15:0] pft_ok  = (upd_out ? upd_bit : 16'h0000)
                        | (route_reg[30] ? 16'h0001 << route_reg[23:20] : 16'h0000);
    wire [7:0]  ctl_ok  = (route_reg[31] && route_reg[29]) ? 8'h01 << route_reg[7:5] : 8'h00;
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            route_reg <= 32'h0000_0000;
            ctrl_reg  <= 12'h000;
        end
        else if (reg_wr && reg_addr == `WOTE_OFF_ROUTE)
            route_reg <= reg_wdata;
        else if (reg_wr && reg_addr == `WOTE_OFF_CTRL)
            ctrl_reg <= reg_wdata[11:0];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ****************************************
    // assertions
    // ****************************************
    chk_conv_together: assert property (conv_update != 2'h0 |-> conv_update == 2'h3)
        else $error("converter strobes not together");
    chk_reset_inputs: assert property (disable iff (1'b0) rst |=> pft_oe == 16'h0000 && ctl_oe == 8'h00)
        else $error("terminal driven after reset");
    chk_idle_quiet: assert property (conv_update != 2'h0 |-> wave_running || $past(wave_running))
        else $error("update while idle");
    chk_stop_halts: assert property (cmd_wr && reg_wdata[1] |-> ##4 (!wave_running && conv_update == 2'h0))
        else $error("engine still running after stop");
    chk_start_runs: assert property (cmd_wr && reg_wdata[0] && !wave_running && ctrl_reg[6:5] == `WOTE_TRIG_SW |-> ##[1:4] wave_running)
        else $error("software start did not run");
    chk_hold_analog: assert property ((ctrl_reg[9:8] == `WOTE_HOLD_ANA && analog_cmp_event)[*5] |-> conv_update == 2'h0)
        else $error("update during analog hold");
    chk_oe_routed: assert property (route_reg == $past(route_reg, 3) |-> (pft_oe & ~pft_ok) == 16'h0000 && (ctl_oe & ~ctl_ok) == 8'h00)
        else $error("unrouted terminal driven");
    chk_upd_idle_high: assert property ((!wave_running)[*4] ##0 (upd_out && route_reg == $past(route_reg, 3)) |-> (pft_oe & pft_out & upd_bit) != 16'h0000)
        else $error("update output not idle high");
endmodule
bind wote_engine wote_engine_chk u_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .analog_cmp_event(analog_cmp_event),
    .pft_out(pft_out), .pft_oe(pft_oe), .ctl_oe(ctl_oe), .conv_update(conv_update),
    .wave_running(wave_running));

// [verification/wote_engine_bench.sv]
// Purpose: self-checking bench for the timing engine
// Assumes: far-side sources on terminals 0 to 3
// Notes:   update out on terminal 4, start trigger out on terminal 6
`timescale 1ns/1ps
`include "wote_consts.vh"
module wote_engine_bench;
    // ****************************************
    // bench
    // ****************************************
    localparam int LIMIT = 40000;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, trig = 1'b0, hold = 1'b0, ext_en = 1'b0;
    logic        analog_cmp_event = 1'b0, clr = 1'b0;
    wire  [31:0] reg_rdata;
    wire  [15:0] pft_in, pft_out, pft_oe;
    wire  [7:0]  ctl_out, ctl_oe;
    wire  [1:0]  conv_update;
    wire         wave_running, fast_base_clock, slow_base_clock;
    int          n_fail = 0, n_compared = 0, cyc = 0, st;
    int          n_upd, n_low, n_trg, last, first, gmin, gmax;
    int          dv[3] = '{3, 2, 2}, nc[3] = '{4, 3, 2}, gp[3] = '{18, 12, 400};
    logic [31:0] cf[3] = '{32'h802, 32'h806, 32'h801}, hc[3] = '{32'h122, 32'h242, 32'h5a2};
    wote_engine u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fast_base_clock(fast_base_clock), .slow_base_clock(slow_base_clock),
        .pft_in(pft_in), .ctl_in(8'h00), .internal_src(8'h00),
        .analog_cmp_event(analog_cmp_event), .pft_out(pft_out), .pft_oe(pft_oe),
        .ctl_out(ctl_out), .ctl_oe(ctl_oe), .conv_update(conv_update),
        .wave_running(wave_running));
    wote_far_side u_far (.core_clk(core_clk), .rst(rst), .trig(trig), .hold(hold),
        .ext_en(ext_en), .pft_in(pft_in), .fast_base_clock(fast_base_clock),
        .slow_base_clock(slow_base_clock));
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (clr)
        begin
            n_upd <= 0;
            n_low <= 0;
            n_trg <= 0;
            gmin  <= LIMIT;
            gmax  <= 0;
        end
        else
        begin
            n_low <= n_low + $fell(pft_out[4]);
            n_trg <= n_trg + $rose(pft_out[6]);
            if (conv_update[0] === 1'b1)
            begin
                n_upd <= n_upd + 1;
                last  <= cyc;
                if (n_upd == 0)
                    first <= cyc;
                if (n_upd != 0 && cyc - last < gmin)
                    gmin <= cyc - last;
                if (n_upd != 0 && cyc - last > gmax)
                    gmax <= cyc - last;
            end
        end
        if (cyc == LIMIT)
        begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 check(what, exp, reg_rdata);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic clear();
        @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
    endtask
    task automatic set_src(input int i, input logic v);
        if (i == 1)
            analog_cmp_event <= v;
        else
            trig <= v;
    endtask
    task automatic set_hold(input int i, input logic v);
        if (i == 1)
            analog_cmp_event <= v;
        else
            hold <= v ^ (i == 2);
    endtask
    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        waitc(20);
        rst <= 1'b0;
        #1 check("oe", 32'h0, {pft_oe, ctl_oe});
        rd(`WOTE_OFF_DIVIDE, `WOTE_DIVIDE_RST, "divide");
        rd(`WOTE_OFF_DELAY, `WOTE_DELAY_RST, "delay");
        rd(4'h8, 32'h0, "unmapped");
        wr(`WOTE_OFF_ROUTE, 32'hc362_0180);
        for (int i = 0; i < 3; i++)
        begin
            wr(`WOTE_OFF_DIVIDE, dv[i]);
            wr(`WOTE_OFF_COUNT, nc[i]);
            wr(`WOTE_OFF_CTRL, cf[i]);
            clear();
            wr(`WOTE_OFF_CMD, 32'h1);
            st = cyc;
            while (wave_running !== 1'b1) @(posedge core_clk);
            while (wave_running !== 1'b0) @(posedge core_clk);
            waitc(4);
            check("updates", nc[i], n_upd);
            check("gap min", gp[i], gmin);
            check("gap max", gp[i], gmax);
            check("first delay", 1, first - st >= gp[i] / dv[i]);
            check("first bound", 1, first - st <= 3 * gp[i] / dv[i]);
            check("out falls", nc[i], n_low);
            check("out idle", 32'h3, {pft_oe[4], pft_out[4]});
            rd(`WOTE_OFF_DONE_CNT, nc[i], "done");
            rd(`WOTE_OFF_STATUS, `WOTE_ST_IDLE, "status");
        end
        wr(`WOTE_OFF_DIVIDE, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            set_hold(i, 1'b0);
            wr(`WOTE_OFF_CTRL, hc[i]);
            wr(`WOTE_OFF_CMD, 32'h1);
            clear();
            waitc(60);
            check("early", 0, n_upd);
            set_src(i, 1'b1);
            waitc(2);
            set_src(i, 1'b0);
            waitc(60);
            check("gap", 6, gmax);
            check("trig out", 1, n_trg);
            set_hold(i, 1'b1);
            waitc(8);
            clear();
            waitc(60);
            check("held", 0, n_upd);
            set_hold(i, 1'b0);
            waitc(60);
            check("resumed", 1, n_upd > 5);
            wr(`WOTE_OFF_CMD, 32'h2);
            waitc(6);
            clear();
            waitc(60);
            check("stopped", 0, n_upd);
        end
        wr(`WOTE_OFF_CTRL, 32'h00a);
        ext_en <= 1'b1;
        wr(`WOTE_OFF_CMD, 32'h1);
        waitc(30);
        clear();
        waitc(100);
        check("ext min", 10, gmin);
        check("ext max", 10, gmax);
        wr(`WOTE_OFF_CMD, 32'h2);
        complete_run();
    end
endmodule
